//--- pkg/nfc_t4_consts.svh
// Offsets, field positions, reset values and status words of the
// pass-through block. Assumes a 13-bit word address and 16-bit data.
`ifndef NFC_T4_CONSTS_SVH
`define NFC_T4_CONSTS_SVH

// ----------------------------------------------------------------
// Register word offsets, buffer window
// ----------------------------------------------------------------
`define NT_REG_INT_EN     13'h0000
`define NT_REG_INT_FLAG   13'h0001
`define NT_REG_STATUS     13'h0002
`define NT_REG_FILE_ID    13'h0003
`define NT_REG_HOST_RESP  13'h0004
`define NT_REG_BLK_LEN    13'h0005
`define NT_REG_FILE_OFF   13'h0006
`define NT_REG_BUF_START  13'h0007
`define NT_REG_CUSTOM_SW  13'h0008
`define NT_BUF_SEL_BIT    12
`define NT_BUF_BYTES      3000

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define NT_INT_GEN_BIT    0
`define NT_HR_SERVICED    0
`define NT_HR_EXISTS      1
`define NT_HR_CUSTOM      2
`define NT_CMD_NONE       2'h0
`define NT_CMD_SELECT     2'h1
`define NT_CMD_READ       2'h2
`define NT_SW_OK          16'h9000
`define NT_SW_NOT_FOUND   16'h6a82
`define NT_RST_INT_EN     1'b0

`endif

//--- pkg/nfc_t4_pkg.sv
// Types shared by the pass-through block and its link tracker.
// Assumes the consts header supplies all numeric values.
package nfc_t4_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_SHIFT_RD, ST_SHIFT_WR, ST_WAIT_HOST,
		ST_TX_ADDR, ST_TX_GRAB, ST_TX_DATA, ST_TX_SW1, ST_TX_SW2
	} eng_state_t;
	typedef enum logic [1:0] {
		AC_OFF, AC_IDLE, AC_READY, AC_ACTIVE
	} ac_state_t;
	typedef struct packed {
		logic        valid;
		logic        is_read;
		logic [15:0] fid;
		logic [15:0] off;
		logic [15:0] len;
	} rdr_cmd_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} resp_t;
	typedef struct packed {
		logic [12:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
	typedef struct packed {
		logic reqb;
		logic attrib;
		logic halt;
	} ac_frame_t;
	typedef struct packed {
		logic atqb;
		logic attrib_ok;
	} ac_answer_t;
	typedef struct packed {
		eng_state_t  state;
		logic        is_read;
		logic [15:0] req_off;
		logic [15:0] req_len;
		logic [15:0] avail;
		logic        cache_valid;
		logic [11:0] cache_start;
		logic [15:0] cache_off;
		logic [15:0] cache_len;
		logic [11:0] shift_src;
		logic [11:0] shift_dst;
		logic [15:0] shift_cnt;
		logic [11:0] tx_idx;
		logic [15:0] tx_cnt;
		logic [15:0] sw;
		logic [7:0]  out_byte;
		logic        int_en;
		logic        int_flag;
		logic [1:0]  status_cmd;
		logic [15:0] file_id;
		logic        hr_exists;
		logic        hr_custom;
		logic [15:0] blk_len;
		logic [15:0] file_off;
		logic [11:0] buf_start;
		logic [15:0] custom_sw;
		logic [15:0] rdata;
		logic        rd_buf;
		logic        irq;
	} regs_t;
endpackage

//--- rtl/nfc_t4_anticoll.sv
// Contactless activation tracker: answers wake-up and attach frames
// alone. Assumes decoded frame pulses on clk and a synchronised field.
`timescale 1ns/1ps
`include "nfc_t4_consts.svh"
module nfc_t4_anticoll (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   field_on,
	input  wire nfc_t4_pkg::ac_frame_t  frame,
	output nfc_t4_pkg::ac_answer_t      answer,
	output logic                        active
);
	import nfc_t4_pkg::*;

	ac_state_t  state;
	ac_state_t  next_state;
	ac_answer_t next_answer;

	always_comb begin
		next_state = state;
		next_answer = '0;
		if (!field_on) begin
			next_state = AC_OFF;
		end else begin
			unique case (state)
				AC_OFF: next_state = AC_IDLE;
				AC_IDLE: if (frame.reqb) begin
					next_answer.atqb = 1'b1;
					next_state = AC_READY;
				end
				AC_READY: if (frame.halt) begin
					next_state = AC_IDLE;
				end else if (frame.attrib) begin
					next_answer.attrib_ok = 1'b1;
					next_state = AC_ACTIVE;
				end
				AC_ACTIVE: if (frame.halt) begin
					next_state = AC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= AC_OFF;
			answer <= '0;
		end else begin
			state <= next_state;
			answer <= next_answer;
		end
	end

	assign active = (state == AC_ACTIVE);
endmodule

//--- rtl/nfc_type4_host_passthrough.sv
// Type 4 pass-through engine: forwards select and read to the host,
// serves cached reads alone. Assumes same-clock reader front end.
// Behaviour
// - Activation finishes before Type 4 commands
// - Select loads file identifier register
// - Forwarded request sets status, flag, interrupt
// - Existing file select answers 90h 00h
// - Missing file select answers 6Ah 82h
// - Custom enable sends custom status word
// - Fully buffered read answers without interrupt
// - Partly or unbuffered read raises interrupt
// - Reads always use last selected file
// - Invalid read sends only custom status
// - Only requested bytes, then status bytes
// - Engine blocks on each forwarded read
// - Partial hit shifts data to start
`timescale 1ns/1ps
`include "nfc_t4_consts.svh"
module nfc_type4_host_passthrough #(
	parameter int BUF_BYTES = `NT_BUF_BYTES
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  field_pin,
	input  wire nfc_t4_pkg::ac_frame_t ac_frame,
	output nfc_t4_pkg::ac_answer_t     ac_answer,
	output logic                       link_active,
	input  wire nfc_t4_pkg::rdr_cmd_t  rdr_cmd,
	output logic                       cmd_ready,
	output nfc_t4_pkg::resp_t          resp,
	input  wire logic                  resp_ready,
	input  wire nfc_t4_pkg::reg_req_t  reg_req,
	output logic [15:0]                reg_rdata,
	output logic                       host_irq_pin
);
	import nfc_t4_pkg::*;

	localparam logic [15:0] BUF_LEN = 16'(BUF_BYTES);

	logic        rst_m;
	logic        rst_sync_n;
	logic        field_m;
	logic        field_s;
	regs_t       r;
	regs_t       n;
	logic        host_done;
	logic        host_owns;
	logic        bus_buf;
	logic        mem_we;
	logic [11:0] mem_wa;
	logic [7:0]  mem_wd;
	logic [11:0] mem_ra;
	logic [7:0]  mem_q;
	logic [7:0]  mem [BUF_BYTES];
	logic [15:0] cache_end;
	logic [15:0] rel;
	logic [15:0] req_end;
	logic [15:0] fill;
	logic        in_cache;
	logic        full_hit;
	logic        accept;
	logic        wr_custom;

	// ----------------------------------------------------------------
	// Reset release and field input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_sync_n <= rst_m;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			field_m <= 1'b0;
			field_s <= 1'b0;
		end else begin
			field_m <= field_pin;
			field_s <= field_m;
		end
	end

	// Activation runs alone, no host involvement
	nfc_t4_anticoll u_anticoll (
		.clk      (clk),
		.rst_n    (rst_sync_n),
		.field_on (field_s),
		.frame    (ac_frame),
		.answer   (ac_answer),
		.active   (link_active)
	);

	// ----------------------------------------------------------------
	// Cache lookup
	// ----------------------------------------------------------------
	assign cache_end = r.cache_off + r.cache_len;
	assign rel       = rdr_cmd.off - r.cache_off;
	assign req_end   = rdr_cmd.off + rdr_cmd.len;
	assign in_cache  = r.cache_valid && rdr_cmd.off >= r.cache_off
	                   && rdr_cmd.off < cache_end;
	assign full_hit  = in_cache && req_end <= cache_end;
	assign fill      = r.avail + r.blk_len;
	assign cmd_ready = (r.state == ST_IDLE) && link_active;
	assign accept    = cmd_ready && rdr_cmd.valid;
	assign host_owns = (r.state == ST_IDLE) || (r.state == ST_WAIT_HOST);
	assign bus_buf   = reg_req.addr[`NT_BUF_SEL_BIT] && host_owns
	                   && ({4'h0, reg_req.addr[11:0]} < BUF_LEN);
	assign host_done = reg_req.wr && reg_req.addr == `NT_REG_HOST_RESP
	                   && reg_req.wdata[`NT_HR_SERVICED];
	assign wr_custom = reg_req.wdata[`NT_HR_CUSTOM];

	// ----------------------------------------------------------------
	// Register port and command engine
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		mem_ra = '0;
		n.rd_buf = 1'b0;
		n.rdata = '0;
		n.irq = r.int_flag & r.int_en;
		if (reg_req.rd) begin
			if (bus_buf) begin
				n.rd_buf = 1'b1;
				mem_ra = reg_req.addr[11:0];
			end else if (!reg_req.addr[`NT_BUF_SEL_BIT]) begin
				unique case (reg_req.addr)
					`NT_REG_INT_EN:    n.rdata = {15'h0000, r.int_en};
					`NT_REG_INT_FLAG:  n.rdata = {15'h0000, r.int_flag};
					`NT_REG_STATUS:    n.rdata = {13'h0000,
					    r.state == ST_WAIT_HOST, r.status_cmd};
					`NT_REG_FILE_ID:   n.rdata = r.file_id;
					`NT_REG_HOST_RESP: n.rdata = {13'h0000,
					    r.hr_custom, r.hr_exists, 1'b0};
					`NT_REG_BLK_LEN:   n.rdata = r.blk_len;
					`NT_REG_FILE_OFF:  n.rdata = r.file_off;
					`NT_REG_BUF_START: n.rdata = {4'h0, r.buf_start};
					`NT_REG_CUSTOM_SW: n.rdata = r.custom_sw;
					default:           n.rdata = '0;
				endcase
			end
		end
		if (reg_req.wr) begin
			if (bus_buf) begin
				mem_we = 1'b1;
				mem_wa = reg_req.addr[11:0];
				mem_wd = reg_req.wdata[7:0];
			end else begin
				unique case (reg_req.addr)
					`NT_REG_INT_EN: n.int_en = reg_req.wdata[`NT_INT_GEN_BIT];
					`NT_REG_INT_FLAG: if (reg_req.wdata[`NT_INT_GEN_BIT]) begin
						n.int_flag = 1'b0;
					end
					`NT_REG_HOST_RESP: begin
						n.hr_exists = reg_req.wdata[`NT_HR_EXISTS];
						n.hr_custom = wr_custom;
					end
					`NT_REG_BLK_LEN:   n.blk_len = reg_req.wdata;
					`NT_REG_CUSTOM_SW: n.custom_sw = reg_req.wdata;
					default: ;
				endcase
			end
		end
		unique case (r.state)
			ST_IDLE: if (accept) begin
				n.is_read = rdr_cmd.is_read;
				if (!rdr_cmd.is_read) begin
					n.file_id = rdr_cmd.fid;
					n.cache_valid = 1'b0;
					n.status_cmd = `NT_CMD_SELECT;
					n.int_flag = 1'b1;
					n.hr_custom = 1'b0;
					n.hr_exists = 1'b0;
					n.state = ST_WAIT_HOST;
				end else if (full_hit) begin
					n.tx_idx = r.cache_start + rel[11:0];
					n.tx_cnt = rdr_cmd.len;
					n.sw = `NT_SW_OK;
					n.state = ST_TX_ADDR;
				end else begin
					// File id stays: reads act on the last select
					n.req_off = rdr_cmd.off;
					n.req_len = rdr_cmd.len;
					n.shift_src = r.cache_start + rel[11:0];
					n.shift_dst = '0;
					n.shift_cnt = in_cache ? cache_end - rdr_cmd.off : '0;
					n.avail = in_cache ? cache_end - rdr_cmd.off : '0;
					n.state = ST_SHIFT_RD;
				end
			end
			ST_SHIFT_RD: if (r.shift_cnt == '0) begin
				n.buf_start = r.avail[11:0];
				n.file_off = r.req_off + r.avail;
				n.blk_len = r.req_len - r.avail;
				n.status_cmd = `NT_CMD_READ;
				n.int_flag = 1'b1;
				n.hr_custom = 1'b0;
				n.hr_exists = 1'b0;
				n.state = ST_WAIT_HOST;
			end else begin
				mem_ra = r.shift_src;
				n.state = ST_SHIFT_WR;
			end
			ST_SHIFT_WR: begin
				// Copy runs low to high, safe as dst never passes src
				mem_we = 1'b1;
				mem_wa = r.shift_dst;
				mem_wd = mem_q;
				n.shift_src = r.shift_src + 12'h001;
				n.shift_dst = r.shift_dst + 12'h001;
				n.shift_cnt = r.shift_cnt - 16'h0001;
				n.state = ST_SHIFT_RD;
			end
			ST_WAIT_HOST: if (host_done) begin
				n.tx_idx = '0;
				n.tx_cnt = '0;
				n.cache_valid = r.is_read && !wr_custom;
				if (wr_custom) begin
					n.sw = r.custom_sw;
				end else if (r.is_read) begin
					n.sw = `NT_SW_OK;
					n.tx_cnt = r.req_len;
					n.cache_start = '0;
					n.cache_off = r.req_off;
					n.cache_len = (fill > BUF_LEN) ? BUF_LEN : fill;
				end else if (reg_req.wdata[`NT_HR_EXISTS]) begin
					n.sw = `NT_SW_OK;
				end else begin
					n.sw = `NT_SW_NOT_FOUND;
				end
				n.state = ST_TX_ADDR;
			end
			ST_TX_ADDR: if (r.tx_cnt == '0) begin
				n.out_byte = r.sw[15:8];
				n.state = ST_TX_SW1;
			end else begin
				mem_ra = r.tx_idx;
				n.state = ST_TX_GRAB;
			end
			ST_TX_GRAB: begin
				n.out_byte = mem_q;
				n.state = ST_TX_DATA;
			end
			ST_TX_DATA: if (resp_ready) begin
				n.tx_idx = r.tx_idx + 12'h001;
				n.tx_cnt = r.tx_cnt - 16'h0001;
				n.state = ST_TX_ADDR;
			end
			ST_TX_SW1: if (resp_ready) begin
				n.out_byte = r.sw[7:0];
				n.state = ST_TX_SW2;
			end
			ST_TX_SW2: if (resp_ready) begin
				n.state = ST_IDLE;
			end
			default: n.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			r <= '0;
			r.int_en <= `NT_RST_INT_EN;
		end else begin
			r <= n;
		end
	end

	// Buffer has no reset; contents are only trusted once written
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		mem_q <= mem[mem_ra];
	end

	assign reg_rdata    = r.rd_buf ? {8'h00, mem_q} : r.rdata;
	assign host_irq_pin = r.irq;
	assign resp.valid   = (r.state == ST_TX_DATA) || (r.state == ST_TX_SW1)
	                      || (r.state == ST_TX_SW2);
	assign resp.data    = r.out_byte;
	assign resp.last    = (r.state == ST_TX_SW2);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_sync_n);

	a_link_after_attach: assert property (
		$rose(link_active) |-> ac_answer.attrib_ok)
		else $error("link active without attach answer");
	a_select_fid: assert property (
		accept && !rdr_cmd.is_read |=> r.file_id == $past(rdr_cmd.fid)
		&& r.status_cmd == `NT_CMD_SELECT)
		else $error("select did not load file id");
	a_irq_raise: assert property (
		(accept && !rdr_cmd.is_read && r.int_en && !reg_req.wr)
		##1 !reg_req.wr |=> host_irq_pin)
		else $error("interrupt pin not raised");
	a_hit_silent: assert property (
		accept && rdr_cmd.is_read && full_hit |=>
		r.state == ST_TX_ADDR && r.sw == `NT_SW_OK && $stable(r.int_flag))
		else $error("buffered read disturbed host");
	a_miss_irq: assert property (
		r.state == ST_SHIFT_RD && r.shift_cnt == '0 |=>
		r.int_flag && r.status_cmd == `NT_CMD_READ
		&& r.state == ST_WAIT_HOST)
		else $error("missing data not requested");
	a_read_keeps_fid: assert property (
		accept && rdr_cmd.is_read |=> $stable(r.file_id))
		else $error("read changed file id");
	a_sel_ok_sw: assert property (
		r.state == ST_WAIT_HOST && host_done && !r.is_read && !wr_custom
		&& reg_req.wdata[`NT_HR_EXISTS] |=> r.sw == `NT_SW_OK
		##1 resp.valid && resp.data == 8'h90)
		else $error("select ok word wrong");
	a_sel_nf_sw: assert property (
		r.state == ST_WAIT_HOST && host_done && !r.is_read && !wr_custom
		&& !reg_req.wdata[`NT_HR_EXISTS] |=> r.sw == `NT_SW_NOT_FOUND)
		else $error("select missing word wrong");
	a_custom_sw: assert property (
		r.state == ST_WAIT_HOST && host_done && wr_custom |=>
		r.sw == $past(r.custom_sw))
		else $error("custom word not used");
	a_custom_nodata: assert property (
		r.state == ST_WAIT_HOST && host_done && wr_custom |=>
		r.tx_cnt == '0 ##1 r.state == ST_TX_SW1)
		else $error("data sent with custom word");
	a_tx_len: assert property (
		r.state == ST_WAIT_HOST && host_done && r.is_read && !wr_custom
		|=> r.tx_cnt == $past(r.req_len))
		else $error("response length wrong");
	a_wait_blocks: assert property (
		r.state == ST_WAIT_HOST && !host_done |=>
		r.state == ST_WAIT_HOST && !resp.valid)
		else $error("response before service");
	a_shift_start: assert property (
		accept && rdr_cmd.is_read && in_cache && !full_hit |=>
		r.state == ST_SHIFT_RD && r.shift_dst == '0 && r.shift_cnt != '0)
		else $error("partial data not shifted");
endmodule

//--- sim/host_model.sv
// Host controller model: services request interrupts over the register
// port. Assumes the consts header, the package and a 10 MHz clk.
`timescale 1ns/1ps
`include "nfc_t4_consts.svh"
module host_model (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           irq,
	input  wire logic [15:0]    rdata,
	input  wire logic           exists,
	input  wire logic           custom_en,
	input  wire logic [15:0]    custom_sw,
	input  wire logic [15:0]    extra,
	input  wire logic [3:0]     slow,
	output nfc_t4_pkg::reg_req_t req,
	output logic [15:0]         seen_fid,
	output logic [15:0]         seen_start,
	output logic [15:0]         seen_off,
	output logic [15:0]         seen_len,
	output logic [15:0]         unmapped_val
);
	import nfc_t4_pkg::*;
	logic [15:0] d;
	logic [15:0] st;
	logic [15:0] fid;
	int          n;

	// ------------------------------------------------------------
	// Register port cycles
	// ------------------------------------------------------------
	task automatic rd(input logic [12:0] a, output logic [15:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic wr(input logic [12:0] a, input logic [15:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	function automatic logic [7:0] fbyte(input logic [15:0] f, input int x);
		return 8'(int'(f) + x * 3 + (x >> 8));
	endfunction

	// ------------------------------------------------------------
	// Interrupt service loop
	// ------------------------------------------------------------
	initial begin
		req = '0;
		fid = 16'h0000;
		wait (rst_n === 1'b1);
		repeat (4) @(posedge clk);
		wr(`NT_REG_INT_EN, 16'h0001);
		rd(13'h0009, unmapped_val);
		forever begin
			@(negedge clk);
			if (irq === 1'b1) begin
				repeat (slow) @(posedge clk);
				rd(`NT_REG_INT_FLAG, d);
				rd(`NT_REG_STATUS, st);
				if (st[1:0] == `NT_CMD_SELECT) begin
					rd(`NT_REG_FILE_ID, fid);
					seen_fid = fid;
				end else begin
					rd(`NT_REG_BUF_START, seen_start);
					rd(`NT_REG_FILE_OFF, seen_off);
					rd(`NT_REG_BLK_LEN, seen_len);
					if (!custom_en) begin
						n = seen_len + extra;
						// Caching stops at the last buffer index
						if (n > `NT_BUF_BYTES - seen_start) begin
							n = `NT_BUF_BYTES - seen_start;
						end
						for (int i = 0; i < n; i++) begin
							wr(13'h1000 | 13'(seen_start + i),
							   {8'h00, fbyte(fid, seen_off + i)});
						end
						wr(`NT_REG_BLK_LEN, 16'(n));
					end
				end
				if (custom_en) begin
					wr(`NT_REG_CUSTOM_SW, custom_sw);
				end
				wr(`NT_REG_INT_FLAG, 16'h0001);
				wr(`NT_REG_HOST_RESP, {13'h0000, custom_en, exists, 1'b1});
			end
		end
	end
endmodule

//--- sim/testbench.sv
// Self-checking bench: reader stimulus, host model, reference model.
// Assumes the consts header, the package and the host model file.
`timescale 1ns/1ps
`include "nfc_t4_consts.svh"
module testbench;
	import nfc_t4_pkg::*;
	logic        clk, rst_n, field_pin, resp_ready, host_irq_pin, irq_d;
	logic        link_active, cmd_ready, exists, custom_en, cache_ok;
	ac_frame_t   ac_frame;
	ac_answer_t  ac_answer;
	rdr_cmd_t    rdr_cmd;
	resp_t       resp;
	reg_req_t    reg_req;
	logic [15:0] reg_rdata, custom_sw, extra, cur_fid;
	logic [15:0] seen_fid, seen_start, seen_off, seen_len, unmapped_val;
	logic [3:0]  slow;
	logic [7:0]  exp_q[$];
	int          err_count, n_tests, n_irq, cache_off, cache_len;
	integer      seed;

	nfc_type4_host_passthrough #(.BUF_BYTES(`NT_BUF_BYTES)) dut_u (
		.clk(clk), .rst_n(rst_n), .field_pin(field_pin),
		.ac_frame(ac_frame), .ac_answer(ac_answer),
		.link_active(link_active), .rdr_cmd(rdr_cmd),
		.cmd_ready(cmd_ready), .resp(resp), .resp_ready(resp_ready),
		.reg_req(reg_req), .reg_rdata(reg_rdata),
		.host_irq_pin(host_irq_pin));

	host_model host_u (
		.clk(clk), .rst_n(rst_n), .irq(host_irq_pin), .rdata(reg_rdata),
		.exists(exists), .custom_en(custom_en), .custom_sw(custom_sw),
		.extra(extra), .slow(slow), .req(reg_req), .seen_fid(seen_fid),
		.seen_start(seen_start), .seen_off(seen_off),
		.seen_len(seen_len), .unmapped_val(unmapped_val));

	// ------------------------------------------------------------
	// Clock, reader stalls, interrupt counting
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Random stalls keep the response byte holding across cycles
	always @(posedge clk) resp_ready <= ($random(seed) & 3) != 0;

	always @(negedge clk) begin
		if (host_irq_pin === 1'b1 && irq_d === 1'b0) n_irq++;
		irq_d = host_irq_pin;
	end

	// ------------------------------------------------------------
	// Checking and reader tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [7:0] fbyte(input logic [15:0] f, input int x);
		return 8'(int'(f) + x * 3 + (x >> 8));
	endfunction

	task automatic run(input logic rdc, input logic [15:0] f, o, l);
		logic [7:0] got[$];
		int         k;
		@(posedge clk);
		rdr_cmd <= '{valid: 1'b1, is_read: rdc, fid: f, off: o, len: l};
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 200);
		@(posedge clk);
		rdr_cmd.valid <= 1'b0;
		for (k = 0; k < 40000; k++) begin
			@(negedge clk);
			if (resp.valid === 1'b1 && resp_ready === 1'b1) begin
				got.push_back(resp.data);
				if (resp.last === 1'b1) break;
			end
		end
		check(16'(got.size()), 16'(exp_q.size()));
		for (k = 0; k < got.size() && k < exp_q.size(); k++) begin
			check({8'h00, got[k]}, {8'h00, exp_q[k]});
		end
	endtask

	task automatic do_select(input logic [15:0] f, input logic ex, cu,
	                         input logic [15:0] sw);
		int irq0;
		exists = ex;
		custom_en = cu;
		custom_sw = sw;
		exp_q.delete();
		if (cu) exp_q = {sw[15:8], sw[7:0]};
		else if (ex) exp_q = {8'h90, 8'h00};
		else exp_q = {8'h6a, 8'h82};
		cache_ok = 1'b0;
		cur_fid = f;
		irq0 = n_irq;
		run(1'b0, f, 16'h0000, 16'h0000);
		check(seen_fid, f);
		check(16'(n_irq - irq0), 16'h0001);
	endtask

	task automatic do_read(input int off, len, ext, input logic cu,
	                       input logic [15:0] sw);
		int   av, n, irq0;
		logic hit;
		hit = cache_ok && off >= cache_off && off + len <= cache_off + cache_len;
		av = 0;
		if (cache_ok && off >= cache_off && off < cache_off + cache_len)
			av = cache_off + cache_len - off;
		custom_en = cu;
		custom_sw = cu ? sw : 16'h9000;
		extra = 16'(ext);
		exp_q.delete();
		for (int i = 0; i < len && !cu; i++) exp_q.push_back(fbyte(cur_fid, off + i));
		exp_q.push_back(custom_sw[15:8]);
		exp_q.push_back(custom_sw[7:0]);
		irq0 = n_irq;
		run(1'b1, cur_fid, 16'(off), 16'(len));
		check(16'(n_irq - irq0), hit ? 16'h0000 : 16'h0001);
		if (!hit) begin
			check(seen_start, 16'(av));
			check(seen_off, 16'(off + av));
			check(seen_len, 16'(len - av));
			n = len - av + ext;
			if (n > `NT_BUF_BYTES - av) n = `NT_BUF_BYTES - av;
			cache_off = off;
			cache_len = av + n;
			cache_ok = !cu;
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		field_pin = 1'b0;
		ac_frame = '0;
		rdr_cmd = '0;
		{exists, custom_en, cache_ok} = 3'b100;
		{custom_sw, extra, cur_fid, slow} = '0;
		{err_count, n_tests, cache_off, cache_len} = '0;
		seed = 23;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		field_pin <= 1'b1;
		repeat (4) @(negedge clk);
		check({15'h0000, cmd_ready}, 16'h0000);
		@(posedge clk);
		ac_frame <= '{reqb: 1'b1, attrib: 1'b0, halt: 1'b0};
		@(posedge clk);
		ac_frame <= '0;
		@(negedge clk);
		check({15'h0000, ac_answer.atqb}, 16'h0001);
		@(posedge clk);
		ac_frame <= '{reqb: 1'b0, attrib: 1'b1, halt: 1'b0};
		@(posedge clk);
		ac_frame <= '0;
		@(negedge clk);
		check({15'h0000, ac_answer.attrib_ok}, 16'h0001);
		@(negedge clk);
		check({15'h0000, link_active}, 16'h0001);
		do_select(16'he103, 1'b1, 1'b0, 16'h0000);
		check(unmapped_val, 16'h0000);
		do_select(16'h5a01, 1'b0, 1'b0, 16'h0000);
		do_select(16'h5a02, 1'b1, 1'b1, 16'h6a81);
		do_select(16'he104, 1'b1, 1'b0, 16'h0000);
		slow = 4'h9;
		do_read(0, 8, 0, 1'b0, 16'h0000);
		do_read(8, 4, 24, 1'b0, 16'h0000);
		do_read(12, 8, 0, 1'b0, 16'h0000);
		do_read(30, 10, 0, 1'b0, 16'h0000);
		do_read(0, 16, 4000, 1'b0, 16'h0000);
		do_read(2990, 16, 0, 1'b0, 16'h0000);
		do_read(100, 8, 0, 1'b1, 16'h6b00);
		for (int r = 0; r < 8; r++) begin
			slow = 4'($random(seed));
			do_read(($random(seed) & 63), 1 + ($random(seed) & 7),
			        ($random(seed) & 15), 1'b0, 16'h0000);
		end
		// Halt drops the link and blocks further commands
		@(posedge clk);
		ac_frame <= '{reqb: 1'b0, attrib: 1'b0, halt: 1'b1};
		@(posedge clk);
		ac_frame <= '0;
		@(negedge clk);
		check({15'h0000, link_active}, 16'h0000);
		check({15'h0000, cmd_ready}, 16'h0000);
		final_report;
	end

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		final_report;
	end
endmodule
